/* rtl/sidc_pkg.sv */
// package for the serial port interrupt and dma control block
// assumes a single 50 MHz clock domain and byte-wide serial framing
package sidc_pkg;
    // ==========================================================
    // control register fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_OPEN_DRAIN_BIT = 4;
    localparam int CTL_TX_IRQ_SEL_BIT = 6;
    localparam int CTL_RX_FLUSH_BIT = 12;
    localparam int CTL_TX_FLUSH_BIT = 13;
    localparam int CTL_THRESH_LO = 14;
    // ==========================================================
    // status register fields
    localparam int STA_IRQ_BIT = 0;
    localparam int STA_TX_UNDERRUN_BIT = 4;
    localparam int STA_TX_IRQ_BIT = 5;
    localparam int STA_RX_IRQ_BIT = 6;
    localparam int STA_RX_OVERFLOW_BIT = 7;
    localparam int STA_CS_ABORT_BIT = 12;
    // ==========================================================
    // dma request control fields
    localparam int DMA_EN_BIT = 0;
    localparam int DMA_TX_BIT = 1;
    localparam int DMA_RX_BIT = 2;
    // ==========================================================
    // sizes and reset values
    localparam int FIFO_DEPTH = 4;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [2:0] DMA_RESET = 3'h0;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [1:0] TX_CNT_RESET = 2'h0;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [15:0] STA_RESET = 16'h0000;
    // ==========================================================
    // serial link byte tracker states
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_BITS = 2'b01
    } sidc_link_t;
endpackage : sidc_pkg

/* rtl/sidc_core.sv */
// interrupt, error, open-drain and dma request logic of a serial port
// assumes shift engine and fifos live outside and report events here;
// chip select and serial clock arrive from pins and are synchronised;
// status read, control write and flush act within one cycle
// How it works
// - one interrupt line, status shows five sources
// - control bit 6 picks tx or rx interrupt
// - tx interrupt every 1 to 4 bytes sent
// - tx interrupt counts sent bytes, not fifo level
// - status read clears tx flag, bit 13 suppresses
// - control write zeroes sent byte counter
// - rx interrupt from fifo level, bit 12 suppresses
// - rx evaluated only when byte enters fifo
// - transfer with empty tx fifo flags underrun
// - byte into full rx fifo flags overflow
// - read or disable clears all, flush clears own
// - open-drain data outputs when control bit 4 set
// - chip select lost mid byte flags abort
// - dma requests gated by enable, tx, rx bits
// - dma mode suppresses threshold interrupts only
// - tx dma request while tx fifo has room
// - master receive stops at programmed byte count
// - byte counter reset on disable or count write
`timescale 1ns/10ps
module sidc_core
    import sidc_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ctl_wr_in,
    input wire logic [15:0] ctl_wdata_in,
    output logic [15:0] port_control_reg_out,
    input wire logic dma_wr_in,
    input wire logic [2:0] dma_wdata_in,
    output logic [2:0] dma_request_control_reg_out,
    input wire logic cnt_wr_in,
    input wire logic [15:0] cnt_wdata_in,
    output logic [15:0] receive_byte_count_reg_out,
    input wire logic bit_counter_reset_in,
    input wire logic sta_rd_in,
    output logic [15:0] port_status_reg_out,
    output logic spi_irq_out,
    input wire logic tx_load_in,
    input wire logic xfer_start_in,
    input wire logic [2:0] tx_level_in,
    input wire logic rx_push_in,
    input wire logic [2:0] rx_level_in,
    input wire logic chip_select_pin_n_in,
    input wire logic sclk_pin_in,
    input wire logic master_rx_byte_in,
    output logic master_rx_allow_out,
    output logic dma_tx_req_out,
    output logic dma_rx_req_out,
    input wire logic mosi_data_in,
    input wire logic mosi_drive_in,
    input wire logic miso_data_in,
    input wire logic miso_drive_in,
    output logic mosi_o_out,
    output logic mosi_oe_out,
    output logic miso_o_out,
    output logic miso_oe_out
);
    // ==========================================================
    // configuration registers
    logic [15:0] ctl_q, ctl_d;
    logic [2:0] dma_q, dma_d;
    logic [15:0] cnt_q, cnt_d;

    // software writes land on the next edge
    always_comb begin
        ctl_d = ctl_wr_in ? ctl_wdata_in : ctl_q;
        dma_d = dma_wr_in ? dma_wdata_in : dma_q;
        cnt_d = cnt_wr_in ? cnt_wdata_in : cnt_q;
    end

    // registers only; reset values come from the package
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctl_q <= CTL_RESET;
            dma_q <= DMA_RESET;
            cnt_q <= CNT_RESET;
        end else begin
            ctl_q <= ctl_d;
            dma_q <= dma_d;
            cnt_q <= cnt_d;
        end
    end

    logic enable, tx_irq_select, rx_flush, tx_flush, dma_mode;
    logic [1:0] thresh;
    // field decode; every field reads the registered control or dma word
    assign enable = ctl_q[CTL_EN_BIT];
    assign tx_irq_select = ctl_q[CTL_TX_IRQ_SEL_BIT];
    assign rx_flush = ctl_q[CTL_RX_FLUSH_BIT];
    assign tx_flush = ctl_q[CTL_TX_FLUSH_BIT];
    assign thresh = ctl_q[CTL_THRESH_LO +: 2];
    assign dma_mode = dma_q[DMA_EN_BIT];

    // ==========================================================
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    logic [2:0] cs_sync_q, cs_sync_d;
    logic [2:0] sck_sync_q, sck_sync_d;
    logic cs_n_q, cs_n_d;
    logic sck_q, sck_d;

    // stage 1 may be metastable, so only stages 2 and 3 are judged
    always_comb begin
        cs_sync_d = {cs_sync_q[1:0], chip_select_pin_n_in};
        sck_sync_d = {sck_sync_q[1:0], sclk_pin_in};
        cs_n_d = (cs_sync_q[2] == cs_sync_q[1]) ? cs_sync_q[2] : cs_n_q;
        sck_d = (sck_sync_q[2] == sck_sync_q[1]) ? sck_sync_q[2] : sck_q;
    end

    // idle pin levels at reset, so no false edge follows release
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cs_sync_q <= 3'h7;
            sck_sync_q <= 3'h0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            cs_sync_q <= cs_sync_d;
            sck_sync_q <= sck_sync_d;
            cs_n_q <= cs_n_d;
            sck_q <= sck_d;
        end
    end

    // ==========================================================
    // byte tracker: counts serial clock rising edges inside a frame
    sidc_link_t link_q, link_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic cs_abort;

    // mode independent: only select, clock, enable and the bit counter reset are watched
    always_comb begin
        link_d = link_q;
        bit_cnt_d = bit_cnt_q;
        cs_abort = 1'b0;
        case (link_q)
            LINK_IDLE: begin
                // counter parked at zero while no frame runs
                bit_cnt_d = BIT_CNT_RESET;
                if (!cs_n_q && enable) begin
                    link_d = LINK_BITS;
                end
            end
            LINK_BITS: begin
                if (cs_n_q || !enable) begin
                    // partial byte lost with select
                    cs_abort = enable && (bit_cnt_q != BIT_CNT_RESET);
                    link_d = LINK_IDLE;
                end else if (sck_d && !sck_q) begin
                    // without bit counter reset the count runs past 8
                    if (bit_cnt_q == 4'(BITS_PER_BYTE - 1)
                        && bit_counter_reset_in) begin
                        bit_cnt_d = BIT_CNT_RESET;
                    end else begin
                        bit_cnt_d = 4'(bit_cnt_q + 4'h1);
                    end
                end
            end
            default: begin
                link_d = LINK_IDLE;
            end
        endcase
    end

    // byte tracker registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            link_q <= LINK_IDLE;
            bit_cnt_q <= BIT_CNT_RESET;
        end else begin
            link_q <= link_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // ==========================================================
    // transmitted byte counter and event decode
    logic [1:0] tx_cnt_q, tx_cnt_d;
    logic tx_event, rx_event, ur_event, of_event;

    // a control write in the load cycle wins, that byte is not counted
    always_comb begin
        tx_cnt_d = tx_cnt_q;
        tx_event = 1'b0;
        if (ctl_wr_in || !enable) begin
            tx_cnt_d = TX_CNT_RESET;
        end else if (tx_load_in) begin
            // counts bytes moved to the shifter
            if (tx_cnt_q == thresh) begin
                tx_cnt_d = TX_CNT_RESET;
                tx_event = 1'b1;
            end else begin
                tx_cnt_d = 2'(tx_cnt_q + 2'h1);
            end
        end
        // rx checked only on push, against level after the push
        rx_event = rx_push_in && !rx_flush
            && (rx_level_in > 3'(thresh));
        ur_event = xfer_start_in && (tx_level_in == 3'h0);
        // level source shows full only on a push into a full fifo
        of_event = rx_push_in && (rx_level_in == 3'(FIFO_DEPTH));
    end

    // sent byte counter register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_cnt_q <= TX_CNT_RESET;
        end else begin
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // ==========================================================
    // sticky status flags; a set in the read cycle survives the read
    logic ur_q, ur_d, txi_q, txi_d, rxi_q, rxi_d;
    logic of_q, of_d, cse_q, cse_d;
    logic clr_all;

    // clear first, then set, so an event in the read cycle is kept
    always_comb begin
        clr_all = sta_rd_in || !enable;
        // threshold interrupts only in the selected direction
        // and never while dma is running
        txi_d = (clr_all || tx_flush) ? 1'b0 : txi_q;
        if (enable && tx_irq_select && !tx_flush && !dma_mode
            && tx_event) begin
            txi_d = 1'b1;
        end
        rxi_d = (clr_all || rx_flush) ? 1'b0 : rxi_q;
        if (enable && !tx_irq_select && !dma_mode && rx_event) begin
            rxi_d = 1'b1;
        end
        // error flags ignore dma mode and threshold
        ur_d = clr_all ? 1'b0 : ur_q;
        if (enable && !tx_flush && ur_event) begin
            ur_d = 1'b1;
        end
        of_d = clr_all ? 1'b0 : of_q;
        if (enable && !rx_flush && of_event) begin
            of_d = 1'b1;
        end
        cse_d = clr_all ? 1'b0 : cse_q;
        if (cs_abort) begin
            cse_d = 1'b1;
        end
    end

    // sticky flag registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            txi_q <= 1'b0;
            rxi_q <= 1'b0;
            ur_q <= 1'b0;
            of_q <= 1'b0;
            cse_q <= 1'b0;
        end else begin
            txi_q <= txi_d;
            rxi_q <= rxi_d;
            ur_q <= ur_d;
            of_q <= of_d;
            cse_q <= cse_d;
        end
    end

    // ==========================================================
    // status word and single interrupt line
    logic irq_line;
    assign irq_line = txi_q | rxi_q | ur_q | of_q | cse_q;

    // unused status bits read as zero
    always_comb begin
        port_status_reg_out = STA_RESET;
        port_status_reg_out[STA_IRQ_BIT] = irq_line;
        port_status_reg_out[STA_TX_UNDERRUN_BIT] = ur_q;
        port_status_reg_out[STA_TX_IRQ_BIT] = txi_q;
        port_status_reg_out[STA_RX_IRQ_BIT] = rxi_q;
        port_status_reg_out[STA_RX_OVERFLOW_BIT] = of_q;
        port_status_reg_out[STA_CS_ABORT_BIT] = cse_q;
    end

    // line and register copies for software readback
    assign spi_irq_out = irq_line;
    assign port_control_reg_out = ctl_q;
    assign dma_request_control_reg_out = dma_q;
    assign receive_byte_count_reg_out = cnt_q;

    // ==========================================================
    // master receive byte counter; a count of zero means unlimited
    logic [15:0] rx_done_q, rx_done_d;

    // counter holds at the limit, so a late byte cannot wrap it
    always_comb begin
        rx_done_d = rx_done_q;
        if (!enable || cnt_wr_in) begin
            rx_done_d = CNT_RESET;
        end else if (master_rx_byte_in && rx_done_q != cnt_q) begin
            // includes the dummy read that opened the transfer
            rx_done_d = 16'(rx_done_q + 16'h0001);
        end
    end

    // received byte counter register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_done_q <= CNT_RESET;
        end else begin
            rx_done_q <= rx_done_d;
        end
    end

    // no new transfer once the count is reached
    assign master_rx_allow_out = (cnt_q == CNT_RESET)
        || (rx_done_q != cnt_q);

    // ==========================================================
    // dma requests: combinational handshakes
    // requests drop the cycle a gate bit falls; none is held over
    // tx asks while room remains; leftover bytes still drain
    assign dma_tx_req_out = enable && dma_q[DMA_EN_BIT] && dma_q[DMA_TX_BIT]
        && (tx_level_in < 3'(FIFO_DEPTH));
    assign dma_rx_req_out = enable && dma_q[DMA_EN_BIT] && dma_q[DMA_RX_BIT]
        && (rx_level_in != 3'h0);

    // ==========================================================
    // data pads: open-drain only pulls low, pull-up gives the high
    logic od;
    assign od = ctl_q[CTL_OPEN_DRAIN_BIT];
    // in open-drain mode a high bit releases the pad
    always_comb begin
        mosi_o_out = od ? 1'b0 : mosi_data_in;
        mosi_oe_out = od ? (mosi_drive_in && !mosi_data_in) : mosi_drive_in;
        miso_o_out = od ? 1'b0 : miso_data_in;
        miso_oe_out = od ? (miso_drive_in && !miso_data_in) : miso_drive_in;
    end
endmodule : sidc_core

/* dv/sidc_core_asserts.sv */
// checker for the interrupt and dma control block
// assumes it is bound to sidc_core and sees only its ports
`timescale 1ns/10ps
module sidc_core_asserts
    import sidc_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ctl_wr_in,
    input wire logic sta_rd_in,
    input wire logic tx_load_in,
    input wire logic xfer_start_in,
    input wire logic rx_push_in,
    input wire logic [2:0] tx_level_in,
    input wire logic [2:0] rx_level_in,
    input wire logic mosi_data_in,
    input wire logic mosi_drive_in,
    input wire logic [15:0] port_control_reg_out,
    input wire logic [2:0] dma_request_control_reg_out,
    input wire logic [15:0] port_status_reg_out,
    input wire logic spi_irq_out,
    input wire logic dma_tx_req_out,
    input wire logic dma_rx_req_out,
    input wire logic mosi_o_out,
    input wire logic mosi_oe_out
);
    // =====
    // short names for the registers
    logic [15:0] c;
    logic [15:0] s;
    logic [2:0] m;
    assign c = port_control_reg_out;
    assign s = port_status_reg_out;
    assign m = dma_request_control_reg_out;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // =====
    // flags, line, requests and open-drain pad
    irq_line_a: assert property (
        spi_irq_out == s[0] && s[0] == (|s[7:4] | s[12]))
        else $error("irq line not the or of sources");
    tx_fire_a: assert property (c[0] && c[6] && !c[13] && !m[0]
        && c[15:14] == 2'h0 && tx_load_in && !ctl_wr_in |=> s[5])
        else $error("tx irq missing");
    rx_fire_a: assert property (c[0] && !c[6] && !c[12] && !m[0]
        && rx_push_in && rx_level_in > {1'b0, c[15:14]}
        && !ctl_wr_in |=> s[6]) else $error("rx irq missing");
    under_set_a: assert property (c[0] && !c[13] && xfer_start_in
        && tx_level_in == 3'h0 && !ctl_wr_in |=> s[4])
        else $error("underrun missing");
    over_set_a: assert property (c[0] && !c[12] && rx_push_in
        && rx_level_in == 3'h4 && !ctl_wr_in |=> s[7])
        else $error("overflow missing");
    read_clear_a: assert property (sta_rd_in && !tx_load_in
        && !xfer_start_in && !rx_push_in |=> s[7:4] == 4'h0)
        else $error("read left a flag");
    off_clear_a: assert property (
        !c[0] |=> s == 16'h0000) else $error("flag while disabled");
    tx_flush_a: assert property (
        c[13] |=> !s[5]) else $error("tx irq under flush");
    dma_quiet_a: assert property (m[0] && (tx_load_in || rx_push_in)
        |=> !$rose(s[5]) && !$rose(s[6]))
        else $error("threshold irq in dma mode");
    dma_gate_a: assert property (!m[0] |->
        !dma_tx_req_out && !dma_rx_req_out) else $error("request ungated");
    dma_room_a: assert property (c[0] && m[0] && m[1] |->
        dma_tx_req_out == (tx_level_in < 3'h4)) else $error("tx request");
    open_drain_a: assert property (c[4] |-> !mosi_o_out
        && mosi_oe_out == (mosi_drive_in && !mosi_data_in))
        else $error("open drain pad");
endmodule : sidc_core_asserts
bind sidc_core sidc_core_asserts u_asserts (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ctl_wr_in(ctl_wr_in),
    .sta_rd_in(sta_rd_in),
    .tx_load_in(tx_load_in),
    .xfer_start_in(xfer_start_in),
    .rx_push_in(rx_push_in),
    .tx_level_in(tx_level_in),
    .rx_level_in(rx_level_in),
    .mosi_data_in(mosi_data_in),
    .mosi_drive_in(mosi_drive_in),
    .port_control_reg_out(port_control_reg_out),
    .dma_request_control_reg_out(dma_request_control_reg_out),
    .port_status_reg_out(port_status_reg_out),
    .spi_irq_out(spi_irq_out),
    .dma_tx_req_out(dma_tx_req_out),
    .dma_rx_req_out(dma_rx_req_out),
    .mosi_o_out(mosi_o_out),
    .mosi_oe_out(mosi_oe_out)
);

/* dv/sidc_far_end.sv */
// far side serial device: drives chip select and serial clock
// assumes 160 ns link clock, still between frames
`timescale 1ns/10ps
module sidc_far_end (
    input wire logic go_in,
    input wire logic [3:0] bits_in,
    output logic cs_n_out,
    output logic sclk_out
);
    // =====
    // one frame per go pulse; a short count cuts a byte off
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    always @(posedge go_in) begin
        #7 cs_n_out = 1'b0; // off grid, unrelated to the core clock
        #80;
        repeat (bits_in) begin
            sclk_out = 1'b1;
            #80 sclk_out = 1'b0;
            #80;
        end
        cs_n_out = 1'b1;
    end
endmodule : sidc_far_end

/* dv/sidc_core_test.sv */
// self-checking bench for the interrupt and dma control block
// assumes one 50 MHz clock; inputs move on the falling edge
`timescale 1ns/10ps
module sidc_core_test
    import sidc_pkg::*;
;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, fr_go = 1'b0;
    logic ctl_wr_in = 1'b0, dma_wr_in = 1'b0, cnt_wr_in = 1'b0;
    logic [15:0] ctl_wdata_in = 16'h0000, cnt_wdata_in = 16'h0000;
    logic [2:0] dma_wdata_in = 3'h0, tx_level_in = 3'h0;
    logic [2:0] rx_level_in = 3'h0;
    logic sta_rd_in = 1'b0, tx_load_in = 1'b0, xfer_start_in = 1'b0;
    logic rx_push_in = 1'b0, master_rx_byte_in = 1'b0;
    logic bit_counter_reset_in = 1'b1, mosi_data_in = 1'b0;
    logic mosi_drive_in = 1'b0, miso_data_in = 1'b0, miso_drive_in = 1'b0;
    logic chip_select_pin_n_in, sclk_pin_in, spi_irq_out;
    logic [3:0] fr_bits = 4'h0, pads;
    logic [15:0] port_control_reg_out, receive_byte_count_reg_out;
    logic [15:0] port_status_reg_out;
    logic [2:0] dma_request_control_reg_out;
    logic master_rx_allow_out, dma_tx_req_out, dma_rx_req_out;
    logic mosi_o_out, mosi_oe_out, miso_o_out, miso_oe_out;
    int error_cnt = 0, checks_done = 0, i;
    assign pads = {mosi_o_out, mosi_oe_out, miso_o_out, miso_oe_out};
    always #10 clk_in = ~clk_in;
    sidc_core u_dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ctl_wr_in(ctl_wr_in),
        .ctl_wdata_in(ctl_wdata_in),
        .port_control_reg_out(port_control_reg_out),
        .dma_wr_in(dma_wr_in),
        .dma_wdata_in(dma_wdata_in),
        .dma_request_control_reg_out(dma_request_control_reg_out),
        .cnt_wr_in(cnt_wr_in),
        .cnt_wdata_in(cnt_wdata_in),
        .receive_byte_count_reg_out(receive_byte_count_reg_out),
        .bit_counter_reset_in(bit_counter_reset_in),
        .sta_rd_in(sta_rd_in),
        .port_status_reg_out(port_status_reg_out),
        .spi_irq_out(spi_irq_out),
        .tx_load_in(tx_load_in),
        .xfer_start_in(xfer_start_in),
        .tx_level_in(tx_level_in),
        .rx_push_in(rx_push_in),
        .rx_level_in(rx_level_in),
        .chip_select_pin_n_in(chip_select_pin_n_in),
        .sclk_pin_in(sclk_pin_in),
        .master_rx_byte_in(master_rx_byte_in),
        .master_rx_allow_out(master_rx_allow_out),
        .dma_tx_req_out(dma_tx_req_out),
        .dma_rx_req_out(dma_rx_req_out),
        .mosi_data_in(mosi_data_in),
        .mosi_drive_in(mosi_drive_in),
        .miso_data_in(miso_data_in),
        .miso_drive_in(miso_drive_in),
        .mosi_o_out(mosi_o_out),
        .mosi_oe_out(mosi_oe_out),
        .miso_o_out(miso_o_out),
        .miso_oe_out(miso_oe_out)
    );
    sidc_far_end u_far (.go_in(fr_go), .bits_in(fr_bits),
        .cs_n_out(chip_select_pin_n_in), .sclk_out(sclk_pin_in));
    // =====
    // access tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // k picks control, dma or count register
    task automatic wr(input int k, input logic [15:0] v);
        {ctl_wdata_in, cnt_wdata_in, dma_wdata_in} = {v, v, v[2:0]};
        {ctl_wr_in, dma_wr_in, cnt_wr_in} = {k == 0, k == 1, k == 2};
        @(negedge clk_in);
        {ctl_wr_in, dma_wr_in, cnt_wr_in} = 3'h0;
        @(negedge clk_in);
    endtask : wr
    task automatic pe(input logic [3:0] p, input logic [2:0] lv);
        {master_rx_byte_in, rx_push_in, xfer_start_in, tx_load_in} = p;
        {tx_level_in, rx_level_in} = {lv, lv};
        @(negedge clk_in);
        {master_rx_byte_in, rx_push_in, xfer_start_in, tx_load_in} = 4'h0;
        @(negedge clk_in);
    endtask : pe
    // a read must leave every flag clear
    task automatic rd(input logic [15:0] exp);
        chk(port_status_reg_out, exp);
        chk(16'(spi_irq_out), 16'(exp[0]));
        sta_rd_in = 1'b1;
        @(negedge clk_in);
        sta_rd_in = 1'b0;
        @(negedge clk_in);
        chk(port_status_reg_out, 16'h0000);
        chk(16'(spi_irq_out), 16'h0000);
    endtask : rd
    // waits out the frame until the abort flag shows, bounded at 90 cycles
    task automatic frame(input logic [3:0] n);
        {fr_bits, fr_go} = {n, 1'b1};
        @(negedge clk_in);
        fr_go = 1'b0;
        for (i = 0; i < 90 && !port_status_reg_out[12]; i++) begin
            @(negedge clk_in);
        end
    endtask : frame
    task automatic note(input string n);
        $display("test %s done", n);
    endtask : note
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // =====
    // tests
    initial begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'b0;
        @(negedge clk_in);
        for (i = 0; i < 4; i++) begin
            wr(0, 16'h0041 | (16'(i) << 14));
            repeat (i) pe(4'h1, 3'h1);
            wr(0, 16'h0041 | (16'(i) << 14));
            repeat (i) pe(4'h1, 3'h1);
            chk(port_status_reg_out, 16'h0000);
            pe(4'h1, 3'h1);
            rd(16'h0021);
        end
        note("tx");
        wr(0, 16'h4001);
        chk(port_control_reg_out, 16'h4001);
        pe(4'h4, 3'h1);
        chk(port_status_reg_out, 16'h0000);
        pe(4'h4, 3'h2);
        rd(16'h0041);
        pe(4'h4, 3'h4);
        rd(16'h00C1);
        wr(0, 16'h5001);
        pe(4'h2, 3'h0);
        wr(0, 16'h4041);
        chk(port_status_reg_out, 16'h0011);
        wr(0, 16'h4000);
        chk(port_status_reg_out, 16'h0000);
        wr(0, 16'h4001);
        pe(4'h4, 3'h2);
        wr(0, 16'h5001);
        chk(port_status_reg_out, 16'h0000);
        wr(0, 16'h3041);
        pe(4'h3, 3'h0);
        pe(4'h4, 3'h4);
        chk(port_status_reg_out, 16'h0000);
        note("rx");
        wr(0, 16'h0041);
        pe(4'h4, 3'h2);
        chk(port_status_reg_out, 16'h0000);
        wr(1, 16'h0003);
        chk(16'(dma_request_control_reg_out), 16'h0003);
        pe(4'h1, 3'h3);
        chk({dma_tx_req_out, dma_rx_req_out}, 2'b10);
        pe(4'h2, 3'h0);
        rd(16'h0011);
        pe(4'h0, 3'h4);
        chk({dma_tx_req_out, dma_rx_req_out}, 2'b00);
        wr(1, 16'h0005);
        chk({dma_tx_req_out, dma_rx_req_out}, 2'b01);
        wr(1, 16'h0006);
        chk({dma_tx_req_out, dma_rx_req_out}, 2'b00);
        wr(1, 16'h0000);
        note("dma");
        {mosi_drive_in, miso_drive_in} = 2'b11;
        wr(0, 16'h0011);
        chk(pads, 4'h5);
        {mosi_data_in, miso_data_in} = 2'b11;
        #1 chk(pads, 4'h0);
        wr(0, 16'h0001);
        chk(pads, 4'hF);
        note("pads");
        frame(4'h5);
        rd(16'h1001);
        frame(4'h8);
        chk(port_status_reg_out, 16'h0000);
        wr(0, 16'h0000);
        wr(0, 16'h0001);
        note("abort");
        wr(2, 16'h0002);
        chk(receive_byte_count_reg_out, 16'h0002);
        pe(4'h8, 3'h0);
        chk(master_rx_allow_out, 1'b1);
        pe(4'h8, 3'h0);
        chk(master_rx_allow_out, 1'b0);
        wr(2, 16'h0002);
        chk(master_rx_allow_out, 1'b1);
        pe(4'h8, 3'h0);
        pe(4'h8, 3'h0);
        chk(master_rx_allow_out, 1'b0);
        wr(0, 16'h0000);
        chk(master_rx_allow_out, 1'b1);
        note("count");
        complete_run();
    end
    // tests need about 300 cycles; 5000 means a hang
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : sidc_core_test
